// ### hw/tae_map.svh
// Purpose: Register offsets, field positions, reset values and channel numbers
// Assumes: Register offsets are word indexes; the byte address is four times the index
// Notes:   Definitions only
`ifndef TAE_MAP_SVH
`define TAE_MAP_SVH

`define TAE_IDX_EV_ALERT    8'h04
`define TAE_IDX_EV_CRIT     8'h05
`define TAE_IDX_EV_BATT     8'h06
`define TAE_IDX_EV_SUPPLY   8'h08
`define TAE_IDX_M_ALERT     8'h11
`define TAE_IDX_M_CRIT      8'h12
`define TAE_IDX_M_BATT      8'h13
`define TAE_IDX_M_SUPPLY    8'h15
`define TAE_IDX_THR_BASE    8'h20
`define TAE_IDX_THR_LAST    8'h30
`define TAE_IDX_MON_EN      8'h90
`define TAE_IDX_CRIT_EN     8'h91
`define TAE_IDX_A0_ST       8'h92
`define TAE_IDX_A1_ST       8'h93
`define TAE_IDX_SUP_ST      8'h94
`define TAE_IDX_SUP_RES     8'h95
`define TAE_IDX_CRIT_ST     8'hbd

`define TAE_RST_EV          8'h00
`define TAE_RST_M_ALERT     8'hff
`define TAE_RST_M_CRIT      8'h0f
`define TAE_RST_M_BATT      8'h3f
`define TAE_RST_M_SUPPLY    8'h03
`define TAE_RST_EN          6'h00
`define TAE_RST_THR         10'h000

// Threshold slots: 0-5 alert0, 6-11 alert1, 12-14 platform critical, 15 die, 16 battery
`define TAE_THR_A1_OFS      5'h06
`define TAE_THR_CR_PLAT     5'h0c
`define TAE_THR_CR_DIE      5'h0f
`define TAE_THR_CRITICAL_TEMP_THRESHOLD       5'h10

// Sensor order: platform 0,1,2, battery 0,1, die
`define TAE_SNS_DIE         3'h5
`define TAE_CH_DIE          4'h2
`define TAE_CH_BAT0         4'h3
`define TAE_CH_BAT1         4'h4
`define TAE_CH_PLAT0        4'h5
`define TAE_CH_PLAT1        4'h6
`define TAE_CH_PLAT2        4'h7
`define TAE_CH_SUPPLY       4'h8

`endif

// ### hw/tae_pkg.sv
// Purpose: Types shared by the thermal alert event logic
// Assumes: Fixed six sensors, 10-bit samples
// Notes:   Constants live in tae_map.svh
package tae_pkg;

    // ADC result stream, same clock as the block
    typedef struct packed {
        logic       valid;
        logic [3:0] channel;
        logic [9:0] data;
    } tae_adc_t;

    // Asynchronous comparator and platform-state pins
    typedef struct packed {
        logic host_fully_active_state;
        logic die_hot;
        logic over_voltage;
        logic under_voltage;
    } tae_pins_t;

    typedef struct packed {
        logic a0;
        logic a1;
        logic cr;
    } tae_sts_t;

    typedef struct packed {
        tae_pins_t s1;
        tae_pins_t s2;
    } tae_sync_state_t;

    typedef struct packed {
        logic [5:0]       mon_en;
        logic [5:0]       crit_en;
        logic [5:0]       a0_st;
        logic [5:0]       a1_st;
        logic [5:0]       cr_st;
        logic [7:0]       ev_alert;
        logic [7:0]       ev_crit;
        logic [7:0]       ev_batt;
        logic [7:0]       ev_supply;
        logic [7:0]       m_alert;
        logic [7:0]       m_crit;
        logic [7:0]       m_batt;
        logic [7:0]       m_supply;
        logic [16:0][9:0] thr;
        logic [5:0][9:0]  smp;
        logic [5:0]       smp_vld;
        logic [9:0]       supply_smp;
        logic [1:0]       sup_st;
        logic             waitreq;
        logic [31:0]      rdata;
        logic             irq;
        logic             warn;
        logic             shdn;
    } tae_state_t;

endpackage : tae_pkg

// ### hw/tae_sync.sv
// Purpose: Two-stage synchroniser for the asynchronous monitor pins
// Assumes: Pins are quasi-static levels
// Notes:   First stage is read only by the second stage
`timescale 1ns/10ps
`default_nettype none
module tae_sync (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire tae_pkg::tae_pins_t pins_in,
    output var  tae_pkg::tae_pins_t pins_out
);
    tae_pkg::tae_sync_state_t st_ff;
    tae_pkg::tae_sync_state_t nxt_st;

    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = pins_in;
        nxt_st.s2 = st_ff.s1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pins_out = st_ff.s2;
endmodule : tae_sync
`default_nettype wire

// ### hw/tae_cmp.sv
// Purpose: Threshold comparison for one temperature sensor
// Assumes: Lower ADC code means hotter
// Notes:   Combinational; the caller registers the result
`timescale 1ns/10ps
`default_nettype none
module tae_cmp (
    input  wire logic             smp_vld,
    input  wire logic [9:0]       smp,
    input  wire logic             mon_en,
    input  wire logic             crit_en,
    input  wire logic [9:0]       thr_a0,
    input  wire logic [9:0]       thr_a1,
    input  wire logic [9:0]       thr_cr,
    input  wire logic             hot_cmp,
    output var  tae_pkg::tae_sts_t sts
);
    always_comb begin
        sts.a0 = mon_en & smp_vld & (smp <= thr_a0);                  // [R09] [R19]
        sts.a1 = mon_en & smp_vld & (smp <= thr_a1);                  // [R10] [R19]
        sts.cr = crit_en & ((smp_vld & (smp <= thr_cr)) | hot_cmp);   // [R11] [R15] [R19]
    end
endmodule : tae_cmp
`default_nettype wire

// ### hw/tae_top.sv
// Purpose: Thermal alert and supply event logic with Avalon-MM register access
// Assumes: ADC results arrive on the block clock; comparator pins are asynchronous
// Notes:   Event bits are write-one-to-clear; a new event in the clearing cycle wins
//
// Functional notes
// R01 - Supply rail sample from ADC input 8 is kept only in host active state
// R02 - Die temperature from live comparator and ADC input 2
// R03 - Battery sensors sampled from ADC inputs 3 and 4
// R04 - Platform sensors sampled from ADC inputs 5, 6 and 7
// R05 - Under- and over-voltage comparator flags are monitored conditions
// R06 - Crossings drive warning and shutdown outputs and raise interrupts
// R07 - Monitor enable register, six sensor bits, reset zero, one enables
// R08 - Critical enable register, same bit order and encoding
// R09 - Read-only first alert status, one bit per sensor
// R10 - Read-only second alert status, one bit per sensor
// R11 - Read-only critical status, one bit per sensor
// R12 - Alert event register: first alerts low nibble, second alerts high nibble
// R13 - Critical event register: platform 0, 1, 2 and die in bits 0-3
// R14 - Battery events: pairs for first alert, second alert and critical
// R15 - Battery critical fires on crossing the shared critical threshold
// R16 - Alert event mask mirrors layout, reset all ones, one masks
// R17 - Critical event mask bits 0-3, reset 0x0f, one masks
// R18 - Battery event mask six bits, reset 0x3f, one masks
// R19 - Lower ADC result counts as higher temperature
// R20 - Interrupt asserted while any unmasked event bit is set
// R21 - Host clears events by writing; events stay set until cleared
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "tae_map.svh"
module tae_top (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic [9:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic [31:0]             avs_readdata,
    output logic                    avs_waitrequest,
    input  wire tae_pkg::tae_adc_t  adc_in,
    input  wire tae_pkg::tae_pins_t mon_pins,
    output logic                    irq,
    output logic                    thermal_warning,
    output logic                    shutdown_request
);
    tae_pkg::tae_state_t  st_ff;
    tae_pkg::tae_state_t  nxt_st;
    tae_pkg::tae_pins_t   pins_s;
    tae_pkg::tae_sts_t    sts [6];
    logic [5:0]           a0_new;
    logic [5:0]           a1_new;
    logic [5:0]           cr_new;
    logic [5:0]           a0_rise;
    logic [5:0]           a1_rise;
    logic [5:0]           cr_rise;
    logic [1:0]           sup_rise;
    logic [7:0]           idx;
    logic                 acc;
    logic                 wr_acc;
    logic [7:0]           wb;
    logic [4:0]           thr_idx;
    logic                 thr_hit;
    logic [31:0]          rd_val;

    // Sensor slot for an ADC channel; 3'h7 means no temperature sensor
    function automatic logic [2:0] chan_to_sensor(input logic [3:0] ch);
        logic [2:0] s;
        s = 3'h7;
        unique case (ch)
            `TAE_CH_PLAT0: s = 3'h0;                                    // [R04]
            `TAE_CH_PLAT1: s = 3'h1;                                    // [R04]
            `TAE_CH_PLAT2: s = 3'h2;                                    // [R04]
            `TAE_CH_BAT0:  s = 3'h3;                                    // [R03]
            `TAE_CH_BAT1:  s = 3'h4;                                    // [R03]
            `TAE_CH_DIE:   s = `TAE_SNS_DIE;                            // [R02]
            default:       s = 3'h7;
        endcase
        return s;
    endfunction : chan_to_sensor

    // Critical threshold slot; both batteries share one programmed value
    function automatic logic [4:0] crit_slot(input int s);
        logic [4:0] r;
        if (s < 3) begin
            r = `TAE_THR_CR_PLAT + 5'(s);
        end else if (s == 5) begin
            r = `TAE_THR_CR_DIE;
        end else begin
            r = `TAE_THR_CRITICAL_TEMP_THRESHOLD;                                         // [R15]
        end
        return r;
    endfunction : crit_slot

    tae_sync u_sync (
        .clk      (clk),
        .rst      (rst),
        .pins_in  (mon_pins),
        .pins_out (pins_s)
    );

    // One comparator per sensor; only the die sensor has a live hardware comparator
    for (genvar i = 0; i < 6; i++) begin : g_sns
        tae_cmp u_cmp (
            .smp_vld (st_ff.smp_vld[i]),
            .smp     (st_ff.smp[i]),
            .mon_en  (st_ff.mon_en[i]),
            .crit_en (st_ff.crit_en[i]),
            .thr_a0  (st_ff.thr[i]),
            .thr_a1  (st_ff.thr[i + 6]),
            .thr_cr  (st_ff.thr[crit_slot(i)]),
            .hot_cmp ((i == 5) ? pins_s.die_hot : 1'b0),                // [R02]
            .sts     (sts[i])
        );
        assign a0_new[i] = sts[i].a0;
        assign a1_new[i] = sts[i].a1;
        assign cr_new[i] = sts[i].cr;
    end

    assign a0_rise  = a0_new & ~st_ff.a0_st;
    assign a1_rise  = a1_new & ~st_ff.a1_st;
    assign cr_rise  = cr_new & ~st_ff.cr_st;
    assign sup_rise = {pins_s.over_voltage, pins_s.under_voltage} & ~st_ff.sup_st; // [R05]

    // Bus decode: a request is accepted on the edge where waitrequest is low
    assign idx     = avs_address[9:2];
    assign acc     = (avs_read | avs_write) & ~st_ff.waitreq;
    assign wr_acc  = acc & avs_write;
    assign wb      = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;
    assign thr_hit = (idx >= `TAE_IDX_THR_BASE) && (idx <= `TAE_IDX_THR_LAST);
    assign thr_idx = 5'(idx - `TAE_IDX_THR_BASE);

    // Read mux; unmapped words and reserved bits read zero
    always_comb begin
        rd_val = 32'h0000_0000;
        if (thr_hit) begin
            rd_val[9:0] = st_ff.thr[thr_idx];
        end else begin
            case (idx)
                `TAE_IDX_EV_ALERT:  rd_val[7:0] = st_ff.ev_alert;
                `TAE_IDX_EV_CRIT:   rd_val[7:0] = st_ff.ev_crit;
                `TAE_IDX_EV_BATT:   rd_val[7:0] = st_ff.ev_batt;
                `TAE_IDX_EV_SUPPLY: rd_val[7:0] = st_ff.ev_supply;
                `TAE_IDX_M_ALERT:   rd_val[7:0] = st_ff.m_alert;
                `TAE_IDX_M_CRIT:    rd_val[7:0] = st_ff.m_crit;
                `TAE_IDX_M_BATT:    rd_val[7:0] = st_ff.m_batt;
                `TAE_IDX_M_SUPPLY:  rd_val[7:0] = st_ff.m_supply;
                `TAE_IDX_MON_EN:    rd_val[5:0] = st_ff.mon_en;        // [R07]
                `TAE_IDX_CRIT_EN:   rd_val[5:0] = st_ff.crit_en;       // [R08]
                `TAE_IDX_A0_ST:     rd_val[5:0] = st_ff.a0_st;         // [R09]
                `TAE_IDX_A1_ST:     rd_val[5:0] = st_ff.a1_st;         // [R10]
                `TAE_IDX_CRIT_ST:   rd_val[5:0] = st_ff.cr_st;         // [R11]
                `TAE_IDX_SUP_ST:    rd_val[2:0] = {pins_s.host_fully_active_state,
                                                   st_ff.sup_st};
                `TAE_IDX_SUP_RES:   rd_val[9:0] = st_ff.supply_smp;
                default:            rd_val = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        logic [2:0] sns;
        logic [7:0] clr_alert;
        logic [7:0] clr_crit;
        logic [7:0] clr_batt;
        logic [7:0] clr_sup;
        logic [7:0] set_alert;
        logic [7:0] set_crit;
        logic [7:0] set_batt;
        logic [7:0] set_sup;
        sns       = chan_to_sensor(adc_in.channel);
        clr_alert = 8'h00;
        clr_crit  = 8'h00;
        clr_batt  = 8'h00;
        clr_sup   = 8'h00;
        set_alert = 8'h00;
        set_crit  = 8'h00;
        set_batt  = 8'h00;
        set_sup   = 8'h00;
        nxt_st    = st_ff;

        // Capture ADC samples per sensor
        if (adc_in.valid && (sns != 3'h7)) begin
            nxt_st.smp[sns]     = adc_in.data;                          // [R02] [R03] [R04]
            nxt_st.smp_vld[sns] = 1'b1;
        end
        // Supply rail is only measured while the host is fully active
        if (adc_in.valid && (adc_in.channel == `TAE_CH_SUPPLY)
                && pins_s.host_fully_active_state) begin
            nxt_st.supply_smp = adc_in.data;                            // [R01]
        end

        nxt_st.a0_st  = a0_new;                                         // [R09]
        nxt_st.a1_st  = a1_new;                                         // [R10]
        nxt_st.cr_st  = cr_new;                                         // [R11]
        nxt_st.sup_st = {pins_s.over_voltage, pins_s.under_voltage};    // [R05]

        // Event mapping from status rises
        set_alert = {a1_rise[5], a1_rise[2:0], a0_rise[5], a0_rise[2:0]};        // [R12]
        set_crit  = {4'h0, cr_rise[5], cr_rise[2:0]};                             // [R13]
        set_batt  = {2'b00, cr_rise[4:3], a1_rise[4:3], a0_rise[4:3]};            // [R14] [R15]
        set_sup   = {6'h00, sup_rise};                                            // [R05]

        // Register writes
        if (wr_acc) begin
            if (thr_hit) begin
                if (avs_byteenable[0]) begin
                    nxt_st.thr[thr_idx][7:0] = avs_writedata[7:0];
                end
                if (avs_byteenable[1]) begin
                    nxt_st.thr[thr_idx][9:8] = avs_writedata[9:8];
                end
            end else if (avs_byteenable[0]) begin
                case (idx)
                    `TAE_IDX_EV_ALERT:  clr_alert = wb;                  // [R21]
                    `TAE_IDX_EV_CRIT:   clr_crit  = wb & 8'h0f;          // [R21]
                    `TAE_IDX_EV_BATT:   clr_batt  = wb & 8'h3f;          // [R21]
                    `TAE_IDX_EV_SUPPLY: clr_sup   = wb & 8'h03;
                    `TAE_IDX_M_ALERT:   nxt_st.m_alert  = wb;            // [R16]
                    `TAE_IDX_M_CRIT:    nxt_st.m_crit   = wb & 8'h0f;    // [R17]
                    `TAE_IDX_M_BATT:    nxt_st.m_batt   = wb & 8'h3f;    // [R18]
                    `TAE_IDX_M_SUPPLY:  nxt_st.m_supply = wb & 8'h03;
                    `TAE_IDX_MON_EN:    nxt_st.mon_en   = wb[5:0];       // [R07]
                    `TAE_IDX_CRIT_EN:   nxt_st.crit_en  = wb[5:0];       // [R08]
                    default:            nxt_st.m_alert  = st_ff.m_alert;
                endcase
            end
        end

        // Sticky events: a set in the clearing cycle wins
        nxt_st.ev_alert  = (st_ff.ev_alert  & ~clr_alert) | set_alert;  // [R12] [R21]
        nxt_st.ev_crit   = (st_ff.ev_crit   & ~clr_crit)  | set_crit;   // [R13] [R21]
        nxt_st.ev_batt   = (st_ff.ev_batt   & ~clr_batt)  | set_batt;   // [R14] [R21]
        nxt_st.ev_supply = (st_ff.ev_supply & ~clr_sup)   | set_sup;    // [R21]

        // Interrupt is formed from the next event and mask state so it registers on the same edge as the events
        nxt_st.irq  = |(nxt_st.ev_alert  & ~nxt_st.m_alert)             // [R16] [R20]
                    | |(nxt_st.ev_crit   & ~nxt_st.m_crit)              // [R17] [R20]
                    | |(nxt_st.ev_batt   & ~nxt_st.m_batt)              // [R18] [R20]
                    | |(nxt_st.ev_supply & ~nxt_st.m_supply);           // [R20]
        nxt_st.warn = |a0_new | |a1_new | pins_s.under_voltage;         // [R06]
        nxt_st.shdn = |cr_new | pins_s.over_voltage;                    // [R06]

        // Fixed one-cycle wait keeps the slave simple at the cost of bus throughput
        if ((avs_read || avs_write) && st_ff.waitreq) begin
            nxt_st.waitreq = 1'b0;
            // Read data holds across writes until the next accepted read
            if (avs_read) begin
                nxt_st.rdata = rd_val;
            end
        end else begin
            nxt_st.waitreq = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff            <= '0;
            st_ff.mon_en     <= `TAE_RST_EN;
            st_ff.crit_en    <= `TAE_RST_EN;
            st_ff.ev_alert   <= `TAE_RST_EV;
            st_ff.ev_crit    <= `TAE_RST_EV;
            st_ff.ev_batt    <= `TAE_RST_EV;
            st_ff.ev_supply  <= `TAE_RST_EV;
            st_ff.m_alert    <= `TAE_RST_M_ALERT;
            st_ff.m_crit     <= `TAE_RST_M_CRIT;
            st_ff.m_batt     <= `TAE_RST_M_BATT;
            st_ff.m_supply   <= `TAE_RST_M_SUPPLY;
            st_ff.thr        <= {17{`TAE_RST_THR}};
            st_ff.waitreq    <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign avs_readdata     = st_ff.rdata;
    assign avs_waitrequest  = st_ff.waitreq;
    assign irq              = st_ff.irq;
    assign thermal_warning  = st_ff.warn;
    assign shutdown_request = st_ff.shdn;
endmodule : tae_top
`default_nettype wire

// ### verif/tae_top_assertions.sv
// Purpose: Bus timing, interrupt and output checks on the top ports
// Assumes: One clock; rst is asynchronous, active high
// Notes:   Index 0x50 is unmapped
`timescale 1ns/10ps
`default_nettype none
module tae_chk (
    input wire logic               clk,
    input wire logic               rst,
    input wire logic [9:0]         avs_address,
    input wire logic               avs_read,
    input wire logic               avs_write,
    input wire logic [31:0]        avs_readdata,
    input wire logic               avs_waitrequest,
    input wire tae_pkg::tae_adc_t  adc_in,
    input wire tae_pkg::tae_pins_t mon_pins,
    input wire logic               irq,
    input wire logic               thermal_warning,
    input wire logic               shutdown_request
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wait_drop_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest stayed high after a request");
    wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    wait_idle_a: assert property (!avs_read && !avs_write |=> avs_waitrequest)
        else $error("waitrequest low without a request");
    unmapped_read_a: assert property (avs_read && !avs_waitrequest && avs_address[9:2] == 8'h50
        |-> avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
    rdata_hold_a: assert property (avs_readdata != $past(avs_readdata)
        |-> $past(avs_read && avs_waitrequest)) else $error("read data changed without a read");
    // Sample lands one edge after valid and the event one edge later; pins add two sync stages
    irq_rise_a: assert property ($rose(irq) |-> $past(adc_in.valid, 2)
        || $past(avs_write && !avs_waitrequest) || $past(avs_write && !avs_waitrequest, 2)
        || $past(mon_pins.die_hot, 3) || $past(mon_pins.over_voltage, 3)
        || $past(mon_pins.under_voltage, 3)) else $error("irq rose without a cause");
    irq_fall_a: assert property ($fell(irq) |-> $past(avs_write && !avs_waitrequest))
        else $error("irq fell without a host write");
    ov_shdn_a: assert property (mon_pins.over_voltage [*4] |-> shutdown_request)
        else $error("over-voltage did not request shutdown");
    uv_warn_a: assert property (mon_pins.under_voltage [*4] |-> thermal_warning)
        else $error("under-voltage did not warn");
    rst_quiet_a: assert property ($fell(rst) |-> !irq && !shutdown_request && avs_waitrequest)
        else $error("outputs active after reset");
endmodule : tae_chk
bind tae_top tae_chk tae_chk_i (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .adc_in, .mon_pins, .irq, .thermal_warning, .shutdown_request);
`default_nettype wire

// ### verif/tae_host.sv
// Purpose: Host model, the Avalon-MM master reading and clearing registers
// Assumes: Word index registers at byte address four times the index
// Notes:   Waits have no bound of their own; the bench timeout ends a hang
`timescale 1ns/10ps
`default_nettype none
module tae_host (
    input  wire logic        clk,
    input  wire logic        avs_waitrequest,
    input  wire logic [31:0] avs_readdata,
    output var  logic [9:0]  avs_address,
    output var  logic        avs_read,
    output var  logic        avs_write,
    output var  logic [31:0] avs_writedata,
    output var  logic [3:0]  avs_byteenable
);
    initial begin
        avs_address = 10'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h0;
    end
    // Clearing an event is a write of ones
    task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] idx, output logic [31:0] d);
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_read <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask : rd
endmodule : tae_host
`default_nettype wire

// ### verif/tb_top.sv
// Purpose: Register, event, interrupt and pin scenarios for the thermal event logic
// Assumes: Thresholds 0x100, 0x080, 0x040; lower code is hotter
// Notes:   Outputs are checked at the falling edge, after updates land
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic [9:0]         avs_address;
    logic               avs_read, avs_write, avs_waitrequest, irq, warn, shdn;
    logic [31:0]        avs_writedata, avs_readdata, d;
    logic [3:0]         avs_byteenable;
    tae_pkg::tae_adc_t  adc_in = '0;
    tae_pkg::tae_pins_t mon_pins = '0;
    int                 n_fail = 0, samples_checked = 0, cyc = 0;
    logic [7:0]         ridx [11] = '{8'h04, 8'h05, 8'h06, 8'h11, 8'h12, 8'h13, 8'h90, 8'h91,
                                      8'h92, 8'h93, 8'hbd};
    logic [7:0]         rval [11] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h0f, 8'h3f, 8'h00, 8'h00,
                                      8'h00, 8'h00, 8'h00};
    logic [3:0]         chn [6] = '{4'h5, 4'h6, 4'h7, 4'h3, 4'h4, 4'h2};
    always #25 clk = ~clk;
    tae_top tae_top_i (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .adc_in, .mon_pins, .irq,
        .thermal_warning(warn), .shutdown_request(shdn));
    tae_host tae_host_i (.clk, .avs_waitrequest, .avs_readdata, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable);
    task automatic chk_reg(input logic [7:0] idx, input logic [31:0] e);
        tae_host_i.rd(idx, d);
        samples_checked++;
        if (d !== e) begin
            n_fail++;
            $display("MISMATCH reg %h exp %h got %h", idx, e, d);
        end
    endtask : chk_reg
    task automatic chk_bit(input string n, input logic e);
        @(negedge clk);
        samples_checked++;
        if ((n == "irq" ? irq : n == "warn" ? warn : shdn) !== e) begin
            n_fail++;
            $display("MISMATCH %s exp %b got %b", n, e, n == "irq" ? irq : n == "warn" ? warn : shdn);
        end
    endtask : chk_bit
    task automatic adc(input logic [3:0] ch, input logic [9:0] v);
        @(posedge clk);
        adc_in <= '{1'b1, ch, v};
        @(posedge clk);
        adc_in.valid <= 1'b0;
    endtask : adc
    task automatic conclude();
        $display("Checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    // Bound well above the few hundred cycles the sequence needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 11; k++) chk_reg(ridx[k], {24'h0, rval[k]});
        chk_reg(8'h50, 32'h0);
        tae_host_i.wr(8'h92, 32'hff, 4'hf);
        chk_reg(8'h92, 32'h0);
        adc(4'h8, 10'h155);
        chk_reg(8'h95, 32'h0);
        mon_pins.host_fully_active_state <= 1'b1;
        repeat (4) @(posedge clk);
        adc(4'h8, 10'h155);
        chk_reg(8'h95, 32'h155);
        mon_pins.under_voltage <= 1'b1;
        repeat (4) @(posedge clk);
        chk_bit("warn", 1'b1);
        chk_bit("shdn", 1'b0);
        mon_pins.over_voltage <= 1'b1;
        repeat (4) @(posedge clk);
        chk_bit("shdn", 1'b1);
        mon_pins.over_voltage <= 1'b0;
        mon_pins.under_voltage <= 1'b0;
        repeat (4) @(posedge clk);
        chk_bit("warn", 1'b0);
        tae_host_i.wr(8'h90, 32'h3f, 4'hf);
        tae_host_i.wr(8'h91, 32'h3f, 4'hf);
        chk_reg(8'h90, 32'h3f);
        chk_reg(8'h91, 32'h3f);
        mon_pins.die_hot <= 1'b1;
        repeat (4) @(posedge clk);
        chk_reg(8'hbd, 32'h20);
        chk_reg(8'h05, 32'h08);
        chk_bit("shdn", 1'b1);
        mon_pins.die_hot <= 1'b0;
        repeat (4) @(posedge clk);
        chk_reg(8'hbd, 32'h00);
        for (int k = 0; k < 17; k++)
            tae_host_i.wr(8'h20 + 8'(k), k < 6 ? 32'h100 : k < 12 ? 32'h080 : 32'h040, 4'h3);
        for (int k = 0; k < 6; k++) adc(chn[k], 10'h100);
        chk_reg(8'h92, 32'h3f);
        chk_reg(8'h93, 32'h00);
        chk_reg(8'hbd, 32'h00);
        chk_reg(8'h04, 32'h0f);
        chk_reg(8'h06, 32'h03);
        chk_bit("irq", 1'b0);
        chk_bit("warn", 1'b1);
        adc(4'h5, 10'h101);
        chk_reg(8'h92, 32'h3e);
        chk_reg(8'h04, 32'h0f);
        tae_host_i.wr(8'h11, 32'hfe, 4'hf);
        chk_bit("irq", 1'b1);
        tae_host_i.wr(8'h04, 32'h01, 4'hf);
        chk_bit("irq", 1'b0);
        chk_reg(8'h04, 32'h0e);
        for (int k = 0; k < 6; k++) adc(chn[k], 10'h040);
        chk_reg(8'h93, 32'h3f);
        chk_reg(8'hbd, 32'h3f);
        chk_reg(8'h04, 32'hff);
        chk_reg(8'h05, 32'h0f);
        chk_reg(8'h06, 32'h3f);
        chk_bit("shdn", 1'b1);
        tae_host_i.wr(8'h11, 32'hff, 4'hf);
        chk_bit("irq", 1'b0);
        tae_host_i.wr(8'h12, 32'h07, 4'hf);
        chk_bit("irq", 1'b1);
        tae_host_i.wr(8'h12, 32'h0f, 4'hf);
        chk_bit("irq", 1'b0);
        tae_host_i.wr(8'h13, 32'h1f, 4'hf);
        chk_bit("irq", 1'b1);
        tae_host_i.wr(8'h13, 32'h3f, 4'hf);
        chk_bit("irq", 1'b0);
        conclude();
    end
endmodule : tb_top
`default_nettype wire
